// ===== common/msg_fifo_pkg.sv
// constants shared by the message fifo control block and its store buffer
// assumes a single 200 MHz clock domain and a word-wide register port
package msg_fifo_pkg;

	// ****************************************
	// register indexes
	// ****************************************
	localparam logic CTRL_IDX = 1'b0;
	localparam logic STAT_IDX = 1'b1;

	// ****************************************
	// control word fields
	// ****************************************
	localparam int DEPTH_LSB = 24;
	localparam int DEPTH_W = 5;
	localparam int RESET_REQ_BIT = 10;
	localparam int SEND_REQ_BIT = 9;
	localparam int ADVANCE_BIT = 8;
	localparam int DIRECTION_BIT = 7;
	localparam int REMOTE_REPLY_BIT = 6;
	localparam int STAMP_EN_BIT = 5;
	localparam int IE_LSB = 0;
	localparam int IE_W = 5;

	// ****************************************
	// status word fields
	// ****************************************
	localparam int INDEX_LSB = 8;
	localparam int OUTCOME_LSB = 5;
	localparam int EXHAUSTED_BIT = 4;
	localparam int OVERFLOW_BIT = 3;
	localparam int EMPTY_FULL_BIT = 2;
	localparam int HALF_BIT = 1;
	localparam int ROOM_DATA_BIT = 0;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic RST_RESET_REQ = 1'b1;
	localparam logic RST_SEND_REQ = 1'b0;
	localparam logic RST_DIRECTION = 1'b0;
	localparam logic RST_REMOTE_REPLY = 1'b0;
	localparam logic RST_STAMP_EN = 1'b0;
	localparam logic [4:0] RST_IE = 5'h00;
	localparam logic [4:0] RST_DEPTH_CODE = 5'h00;

	// ****************************************
	// store buffer shape
	// ****************************************
	localparam int STAMP_W = 32;
	localparam int SLOT_W = 5;
	localparam int STORE_W = STAMP_W + SLOT_W + 1;
	localparam int BUF_DEPTH = 4;

endpackage

// ===== rtl/msg_buf.sv
// small valid/ready fifo holding pending message store commands
// assumes source and sink on the same clock; read data from register array
`timescale 1ns/1ps
module msg_buf #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULLC = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] cnt_r;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == LAST) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (cnt_r != FULLC);
	assign out_valid = (cnt_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_r[rd_ptr_r];

	// ****************************************
	// storage, no reset needed on data
	// ****************************************
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= step(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= step(rd_ptr_r);
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule

// ===== rtl/msg_fifo_ctrl.sv
// control and status logic of one configurable message fifo
// assumes an spi front end issuing word writes/reads and a protocol engine
// Behaviour
// - writing reset request clears the fifo; hardware drops the bit afterwards
// - reset request stays set in configuration mode, clears in normal mode
// - send request starts transmit; self-clears only after last queued message sent
// - host writing send request to zero while one asks for abort
// - in receive mode send request writes do nothing
// - transmit advance moves head one slot, committing the written message
// - receive advance moves tail one slot, releasing the read message
// - direction bit one is transmit, zero is receive
// - remote request with auto reply enabled sets send request
// - time stamp enable marks each stored received message for a stamp
// - direction and stamp enable accept writes only in configuration mode
// - five enables gate the five fifo flags onto the request output
// - message index is next transmit slot or next receive slot
// - outcome bits report abort, lost arbitration and bus error
// - outcome bits clear on send request set or host writing zero
// - outcome bits load only on completion or abort; fifo reset clears them
// - attempts exhausted flag pends in transmit, reads zero in receive
// - overflow flag sets on receive overflow, reads zero in transmit
// - empty or full flag: transmit empty, receive full
// - half flag: transmit at most half, receive at least half
// - room or data flag: transmit not full, receive not empty
// - depth code plus one gives depth in messages
`timescale 1ns/1ps
module msg_fifo_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic config_mode,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_sel,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic tx_done,
	input wire logic tx_abort_done,
	input wire logic tx_lost_arb,
	input wire logic tx_bus_err,
	input wire logic tx_attempts_out,
	input wire logic rtr_received,
	output logic tx_request,
	output logic tx_abort_req,
	output logic [4:0] msg_index,
	input wire logic rx_msg_valid,
	input wire logic [31:0] rx_stamp,
	output logic rx_msg_ready,
	output logic store_valid,
	input wire logic store_ready,
	output logic [4:0] store_slot,
	output logic store_stamp_en,
	output logic [31:0] store_stamp,
	output logic irq_req
);
	// ****************************************
	// state
	// ****************************************
	logic reset_req_r;
	logic send_req_r;
	logic abort_req_r;
	logic direction_r;
	logic remote_reply_r;
	logic stamp_en_r;
	logic [4:0] ie_r;
	logic [4:0] depth_code_r;
	logic [4:0] head_r;
	logic [4:0] tail_r;
	logic [5:0] count_r;
	logic [2:0] outcome_r;
	logic exhausted_r;
	logic overflow_r;

	logic ctl_wr;
	logic st_wr;
	logic tx_mode;
	logic [5:0] depth;
	logic full;
	logic empty;
	logic do_fifo_reset_request;
	logic host_adv;
	logic tx_commit;
	logic rx_release;
	logic rx_push;
	logic rx_over;
	logic tx_sent;
	logic set_sr;
	logic host_abort;
	logic inc_head;
	logic inc_tail;
	logic [4:0] flags;
	logic [31:0] status_word;
	logic [31:0] control_word;
	logic buf_in_ready;

	function automatic logic [4:0] wrap(input logic [4:0] p, input logic [4:0] code);
		wrap = (p == code) ? 5'h00 : p + 5'h01;
	endfunction

	// ****************************************
	// decode
	// ****************************************
	assign ctl_wr = reg_wr && (reg_sel == msg_fifo_pkg::CTRL_IDX);
	assign st_wr = reg_wr && (reg_sel == msg_fifo_pkg::STAT_IDX);
	assign tx_mode = direction_r;
	assign depth = {1'b0, depth_code_r} + 6'h01;
	assign full = (count_r == depth);
	assign empty = (count_r == 6'h00);
	assign do_fifo_reset_request = reset_req_r && !config_mode;
	assign host_adv = ctl_wr && reg_wdata[msg_fifo_pkg::ADVANCE_BIT] && !do_fifo_reset_request;
	assign tx_commit = tx_mode && host_adv && !full;
	assign rx_release = !tx_mode && host_adv && !empty;
	assign rx_push = !tx_mode && rx_msg_valid && buf_in_ready && !full && !do_fifo_reset_request;
	// a full receive fifo drops the frame rather than stalling the engine
	assign rx_over = !tx_mode && rx_msg_valid && full && !do_fifo_reset_request;
	assign rx_msg_ready = !tx_mode && (buf_in_ready || full);
	assign tx_sent = tx_mode && tx_done && !empty && !do_fifo_reset_request;
	assign host_abort = tx_mode && ctl_wr && send_req_r
		&& !reg_wdata[msg_fifo_pkg::SEND_REQ_BIT];
	assign set_sr = tx_mode && !do_fifo_reset_request
		&& ((ctl_wr && reg_wdata[msg_fifo_pkg::SEND_REQ_BIT])
		|| (rtr_received && remote_reply_r));
	assign inc_head = tx_commit || rx_push;
	assign inc_tail = tx_sent || rx_release;

	// ****************************************
	// engine side
	// ****************************************
	assign tx_request = tx_mode && send_req_r && !empty && !abort_req_r;
	assign tx_abort_req = abort_req_r;
	assign msg_index = tx_mode ? tail_r : head_r;

	// ****************************************
	// fifo status flags
	// ****************************************
	always_comb begin
		flags = 5'h00;
		if (tx_mode) begin
			flags[4] = exhausted_r;
			flags[2] = empty;
			flags[1] = ({count_r, 1'b0} <= {1'b0, depth});
			flags[0] = !full;
		end else begin
			flags[3] = overflow_r;
			flags[2] = full;
			flags[1] = ({count_r, 1'b0} >= {1'b0, depth});
			flags[0] = !empty;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[msg_fifo_pkg::INDEX_LSB +: 5] = msg_index;
		status_word[msg_fifo_pkg::OUTCOME_LSB +: 3] = outcome_r;
		status_word[msg_fifo_pkg::EXHAUSTED_BIT:0] = flags;
	end

	always_comb begin
		control_word = 32'h0000_0000;
		control_word[msg_fifo_pkg::DEPTH_LSB +: msg_fifo_pkg::DEPTH_W] = depth_code_r;
		control_word[msg_fifo_pkg::RESET_REQ_BIT] = reset_req_r;
		control_word[msg_fifo_pkg::SEND_REQ_BIT] = send_req_r;
		control_word[msg_fifo_pkg::DIRECTION_BIT] = direction_r;
		control_word[msg_fifo_pkg::REMOTE_REPLY_BIT] = remote_reply_r;
		control_word[msg_fifo_pkg::STAMP_EN_BIT] = stamp_en_r;
		control_word[msg_fifo_pkg::IE_LSB +: msg_fifo_pkg::IE_W] = ie_r;
	end

	// ****************************************
	// register port
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= (reg_sel == msg_fifo_pkg::CTRL_IDX) ? control_word : status_word;
			end
		end
	end

	// ****************************************
	// configuration; direction, stamp enable and depth locked outside configuration mode, remote reply and enables always writable
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			direction_r <= msg_fifo_pkg::RST_DIRECTION;
			stamp_en_r <= msg_fifo_pkg::RST_STAMP_EN;
			depth_code_r <= msg_fifo_pkg::RST_DEPTH_CODE;
		end else if (ctl_wr && config_mode) begin
			direction_r <= reg_wdata[msg_fifo_pkg::DIRECTION_BIT];
			stamp_en_r <= reg_wdata[msg_fifo_pkg::STAMP_EN_BIT];
			depth_code_r <= reg_wdata[msg_fifo_pkg::DEPTH_LSB +: msg_fifo_pkg::DEPTH_W];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			remote_reply_r <= msg_fifo_pkg::RST_REMOTE_REPLY;
			ie_r <= msg_fifo_pkg::RST_IE;
		end else if (ctl_wr) begin
			remote_reply_r <= reg_wdata[msg_fifo_pkg::REMOTE_REPLY_BIT];
			ie_r <= reg_wdata[msg_fifo_pkg::IE_LSB +: msg_fifo_pkg::IE_W];
		end
	end

	// ****************************************
	// fifo reset request
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reset_req_r <= msg_fifo_pkg::RST_RESET_REQ;
		end else if (config_mode) begin
			reset_req_r <= 1'b1;
		end else if (ctl_wr && reg_wdata[msg_fifo_pkg::RESET_REQ_BIT]) begin
			reset_req_r <= 1'b1;
		end else if (do_fifo_reset_request) begin
			reset_req_r <= 1'b0;
		end
	end

	// ****************************************
	// pointers and occupancy
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			head_r <= 5'h00;
			tail_r <= 5'h00;
			count_r <= 6'h00;
		end else if (do_fifo_reset_request) begin
			head_r <= 5'h00;
			tail_r <= 5'h00;
			count_r <= 6'h00;
		end else begin
			if (inc_head) begin
				head_r <= wrap(head_r, depth_code_r);
			end
			if (inc_tail) begin
				tail_r <= wrap(tail_r, depth_code_r);
			end
			if (inc_head && !inc_tail) begin
				count_r <= count_r + 6'h01;
			end else if (inc_tail && !inc_head) begin
				count_r <= count_r - 6'h01;
			end
		end
	end

	// ****************************************
	// send request and abort
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			send_req_r <= msg_fifo_pkg::RST_SEND_REQ;
		end else if (do_fifo_reset_request) begin
			send_req_r <= 1'b0;
		end else if (set_sr) begin
			send_req_r <= 1'b1; // set wins over any same-cycle clear except a fifo reset
		end else if (host_abort || (tx_mode && tx_abort_done)) begin
			send_req_r <= 1'b0;
		end else if (tx_sent && count_r == 6'h01 && !tx_commit) begin
			send_req_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			abort_req_r <= 1'b0;
		end else if (do_fifo_reset_request || ((tx_abort_done || tx_done) && !host_abort)) begin
			abort_req_r <= 1'b0;
		end else if (host_abort) begin
			abort_req_r <= 1'b1;
		end
	end

	// ****************************************
	// transmit outcome
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			outcome_r <= 3'h0;
		end else if (do_fifo_reset_request) begin
			outcome_r <= 3'h0;
		end else if (tx_mode && tx_abort_done) begin
			outcome_r <= {1'b1, tx_lost_arb, tx_bus_err};
		end else if (tx_sent) begin
			outcome_r <= {1'b0, tx_lost_arb, tx_bus_err};
		end else if (set_sr) begin
			outcome_r <= 3'h0;
		end else if (st_wr) begin
			outcome_r <= outcome_r & reg_wdata[msg_fifo_pkg::OUTCOME_LSB +: 3];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exhausted_r <= 1'b0;
		end else if (do_fifo_reset_request) begin
			exhausted_r <= 1'b0;
		end else if (tx_mode && tx_attempts_out) begin
			exhausted_r <= 1'b1;
		end else if (st_wr && !reg_wdata[msg_fifo_pkg::EXHAUSTED_BIT]) begin
			exhausted_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overflow_r <= 1'b0;
		end else if (do_fifo_reset_request) begin
			overflow_r <= 1'b0;
		end else if (rx_over) begin
			overflow_r <= 1'b1;
		end else if (st_wr && !reg_wdata[msg_fifo_pkg::OVERFLOW_BIT]) begin
			overflow_r <= 1'b0;
		end
	end

	// ****************************************
	// enabled flags onto the request line
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= |(flags & ie_r);
		end
	end

	// ****************************************
	// store buffer toward message ram
	// ****************************************
	// stamp enable travels with each store, so a later config change cannot
	// retag a frame already queued
	msg_buf #(
		.WIDTH(msg_fifo_pkg::STORE_W),
		.DEPTH(msg_fifo_pkg::BUF_DEPTH)
	) u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(rx_push),
		.in_data({stamp_en_r, head_r, rx_stamp}),
		.in_ready(buf_in_ready),
		.out_valid(store_valid),
		.out_data({store_stamp_en, store_slot, store_stamp}),
		.out_ready(store_ready)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_reset_go;
		reset_req_r && !config_mode && !(ctl_wr && reg_wdata[msg_fifo_pkg::RESET_REQ_BIT]);
	endsequence

	sequence s_abort_end;
		tx_mode && tx_abort_done && !do_fifo_reset_request;
	endsequence

	a_reset_clear: assert property (s_reset_go |=> !reset_req_r && count_r == 6'h00
		&& head_r == 5'h00) else $error("fifo reset did not complete");
	a_config_hold: assert property (config_mode |=> reset_req_r)
		else $error("reset request dropped in configuration mode");
	a_send_fall: assert property ($fell(send_req_r) |-> $past(tx_sent || host_abort
		|| tx_abort_done || do_fifo_reset_request)) else $error("send request cleared early");
	a_abort_raise: assert property (host_abort && !do_fifo_reset_request && !tx_done
		&& !tx_abort_done |=> tx_abort_req) else $error("abort not requested");
	a_rx_inert: assert property (!tx_mode && !send_req_r |=> !send_req_r)
		else $error("send request moved in receive mode");
	a_head_step: assert property (tx_commit |=> head_r
		== wrap($past(head_r), $past(depth_code_r))) else $error("head did not advance one slot");
	a_tail_step: assert property (rx_release |=> tail_r
		== wrap($past(tail_r), $past(depth_code_r))) else $error("tail did not advance one slot");
	a_cfg_lock: assert property (!config_mode |=> $stable(direction_r) && $stable(stamp_en_r))
		else $error("locked setting changed");
	a_outcome_abort: assert property (s_abort_end |=> outcome_r[2] ##1
		(outcome_r[2] || $past(set_sr || st_wr || do_fifo_reset_request || tx_sent))) else $error("abort bit");
	a_exhaust_rx: assert property (!tx_mode |-> !status_word[msg_fifo_pkg::EXHAUSTED_BIT])
		else $error("exhausted flag visible in receive mode");
	a_depth_bound: assert property (count_r <= depth)
		else $error("occupancy beyond depth");
	a_irq_gate: assert property (ie_r == 5'h00 ##1 ie_r == 5'h00 |-> !irq_req)
		else $error("request raised with all enables off");
endmodule

// ===== verification/can_engine_model.sv
// protocol engine stand-in: sends, aborts, offers frames, sinks stores
// assumes the fifo block on the same clock; drives 1 ns after rising edges
`timescale 1ns/1ps
module can_engine_model (
	input wire logic clock,
	input wire logic tx_request,
	input wire logic tx_abort_req,
	input wire logic rx_msg_ready,
	input wire logic stall,
	output logic tx_done,
	output logic tx_abort_done,
	output logic tx_lost_arb,
	output logic tx_bus_err,
	output logic rx_msg_valid,
	output logic [31:0] rx_stamp,
	output logic store_ready
);
	initial begin
		tx_done = 1'b0;
		tx_abort_done = 1'b0;
		tx_lost_arb = 1'b0;
		tx_bus_err = 1'b0;
		rx_msg_valid = 1'b0;
		rx_stamp = 32'h0;
	end
	// stall holds stores back so the bench can fill the buffer
	assign store_ready = !stall;
	// ****************************************
	// abort answer, late as on a busy bus
	// ****************************************
	always @(posedge clock) begin
		#1;
		if (tx_abort_req === 1'b1) begin
			repeat (3) @(posedge clock);
			#1 tx_abort_done = 1'b1;
			tx_lost_arb = 1'b0;
			tx_bus_err = 1'b0;
			@(posedge clock);
			#1 tx_abort_done = 1'b0;
		end
	end
	// ****************************************
	// bench-called transfers
	// ****************************************
	// a message goes out lag cycles after one is requested, or after 50 cycles without a request
	task automatic send(input int lag, input logic larb, input logic err);
		int n;
		n = 0;
		while (tx_request !== 1'b1 && n < 50) begin
			@(posedge clock);
			#1;
			n++;
		end
		repeat (lag) begin
			@(posedge clock);
			#1;
		end
		tx_done = 1'b1;
		tx_lost_arb = larb;
		tx_bus_err = err;
		@(posedge clock);
		#1 tx_done = 1'b0;
		// qualifiers mean nothing outside the pulse
		tx_lost_arb = ~larb;
		tx_bus_err = ~err;
		@(posedge clock);
		#1;
	endtask
	task automatic offer(input logic [31:0] s);
		int n;
		n = 0;
		rx_msg_valid = 1'b1;
		rx_stamp = s;
		// ready settles after each edge and holds until the next one
		while (rx_msg_ready !== 1'b1 && n < 50) begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
		#1 rx_msg_valid = 1'b0;
		rx_stamp = ~s;
		@(posedge clock);
		#1;
	endtask
endmodule

// ===== verification/can_message_fifo_ctrl_status_test.sv
// self-checking bench for the message fifo control block
// assumes can_engine_model as engine; the bench plays the host
`timescale 1ns/1ps
module can_message_fifo_ctrl_status_test;
	typedef struct packed {
		logic wr;
		logic cfg;
		logic sel;
		logic [31:0] wdata;
		logic [31:0] mask;
		logic [31:0] want;
	} row_t;
	localparam logic [31:0] TXC = 32'h030000c0;
	logic clock, rst_n, config_mode, reg_wr, reg_rd, reg_sel, stall, reg_rvalid;
	logic [31:0] reg_wdata, reg_rdata, rx_stamp, store_stamp;
	logic tx_done, tx_abort_done, tx_lost_arb, tx_bus_err, tx_attempts_out, rtr_received;
	logic tx_request, tx_abort_req, rx_msg_valid, rx_msg_ready;
	logic store_valid, store_ready, store_stamp_en, irq_req;
	logic [4:0] msg_index, store_slot;
	logic [37:0] stored[$];
	int num_errors = 0;
	int comparisons = 0;
	row_t rows[4] = '{
		'{1'b1, 1'b1, 1'b0, 32'h03000060, 32'h1f0007ff, 32'h03000460},
		'{1'b1, 1'b0, 1'b0, 32'h1f00009f, 32'h1f0007ff, 32'h0300003f},
		'{1'b0, 1'b0, 1'b1, 32'h0, 32'h1fff, 32'h0},
		'{1'b1, 1'b0, 1'b1, 32'hffffffff, 32'h1fff, 32'h0}
	};
	msg_fifo_ctrl uut (.clock(clock), .rst_n(rst_n), .config_mode(config_mode),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_done(tx_done),
		.tx_abort_done(tx_abort_done), .tx_lost_arb(tx_lost_arb), .tx_bus_err(tx_bus_err),
		.tx_attempts_out(tx_attempts_out), .rtr_received(rtr_received),
		.tx_request(tx_request), .tx_abort_req(tx_abort_req), .msg_index(msg_index),
		.rx_msg_valid(rx_msg_valid), .rx_stamp(rx_stamp), .rx_msg_ready(rx_msg_ready),
		.store_valid(store_valid), .store_ready(store_ready), .store_slot(store_slot),
		.store_stamp_en(store_stamp_en), .store_stamp(store_stamp), .irq_req(irq_req));
	can_engine_model eng (.clock(clock), .tx_request(tx_request),
		.tx_abort_req(tx_abort_req), .rx_msg_ready(rx_msg_ready), .stall(stall),
		.tx_done(tx_done), .tx_abort_done(tx_abort_done), .tx_lost_arb(tx_lost_arb),
		.tx_bus_err(tx_bus_err), .rx_msg_valid(rx_msg_valid), .rx_stamp(rx_stamp),
		.store_ready(store_ready));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (store_valid === 1'b1 && store_ready === 1'b1) begin
			stored.push_back({store_stamp_en, store_slot, store_stamp});
		end
	end
	// ****************************************
	// shared host tasks
	// ****************************************
	task automatic chk(input logic [37:0] got, input logic [37:0] want, input string m);
		comparisons++;
		if (got !== want) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, want);
		end
	endtask
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	// trailing edge keeps back-to-back strobes from colliding in one step
	task automatic wr(input logic s, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_sel = s;
		reg_wdata = d;
		tick();
		reg_wr = 1'b0;
		reg_wdata = ~d;
		tick();
	endtask
	task automatic rd(input logic s, input logic [31:0] mask, input logic [31:0] w, string m);
		reg_rd = 1'b1;
		reg_sel = s;
		tick();
		reg_rd = 1'b0;
		chk(38'(reg_rvalid), 38'h1, "read answer");
		chk(38'(reg_rdata & mask), 38'(w), m);
		tick();
	endtask
	task automatic setup(input logic [31:0] w);
		config_mode = 1'b1;
		wr(1'b0, w);
		config_mode = 1'b0;
		tick();
		rd(1'b0, 32'h400, 32'h0, "reset bit");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, reg_sel, stall, rtr_received, tx_attempts_out} = 7'h00;
		config_mode = 1'b1;
		reg_wdata = 32'h0;
		repeat (12) @(posedge clock);
		#1 rst_n = 1'b1;
		tick();
		foreach (rows[i]) begin
			config_mode = rows[i].cfg;
			if (rows[i].wr) wr(rows[i].sel, rows[i].wdata);
			rd(rows[i].sel, rows[i].mask, rows[i].want, "table row");
		end
		// receive: fill past the buffer, overflow, then release
		setup(32'h07000028);
		stall = 1'b1;
		for (int i = 0; i < 4; i++) eng.offer(32'h100 + 32'(i));
		tick();
		chk(38'(rx_msg_ready), 38'h0, "buffer refusal");
		stall = 1'b0;
		for (int i = 4; i < 8; i++) eng.offer(32'h100 + 32'(i));
		repeat (8) tick();
		rd(1'b1, 32'h1fff, 32'h0007, "rx full");
		eng.offer(32'h1ff);
		rd(1'b1, 32'h1fff, 32'h000f, "rx overflow");
		chk(38'(irq_req), 38'h1, "overflow irq");
		wr(1'b1, 32'h0);
		wr(1'b0, 32'h07000228);
		chk(38'(tx_request), 38'h0, "rx send");
		rd(1'b0, 32'h200, 32'h0, "rx send bit");
		rd(1'b1, 32'h1fff, 32'h0007, "overflow clear");
		chk(38'(irq_req), 38'h0, "irq drop");
		for (int i = 0; i < 4; i++) wr(1'b0, 32'h07000128);
		rd(1'b1, 32'h1fff, 32'h0003, "rx half");
		for (int i = 0; i < 5; i++) wr(1'b0, 32'h07000128);
		rd(1'b1, 32'h1fff, 32'h0000, "rx empty");
		eng.offer(32'h200);
		repeat (4) tick();
		rd(1'b1, 32'h1fff, 32'h0101, "rx index");
		chk(38'(stored.size()), 38'd9, "store count");
		for (int i = 0; i < 8; i++) chk(stored[i], {1'b1, 5'(i), 32'h100 + 32'(i)}, "store");
		chk(stored[8], {1'b1, 5'h00, 32'h200}, "late store");
		// transmit: queue four, outcomes, abort, drain
		setup(TXC);
		rd(1'b1, 32'h1fff, 32'h0007, "tx empty");
		chk(38'(irq_req), 38'h0, "masked irq");
		wr(1'b0, TXC | 32'h4);
		chk(38'(irq_req), 38'h1, "empty irq");
		for (int i = 0; i < 2; i++) wr(1'b0, TXC | 32'h104);
		rd(1'b1, 32'h1fff, 32'h0003, "tx half");
		for (int i = 0; i < 3; i++) wr(1'b0, TXC | 32'h104);
		rd(1'b1, 32'h1fff, 32'h0000, "tx full");
		wr(1'b0, TXC | 32'h204);
		chk(38'(tx_request), 38'h1, "send start");
		eng.send(0, 1'b1, 1'b0);
		rd(1'b1, 32'h1fff, 32'h0141, "lost arbitration");
		chk(38'(msg_index), 38'h1, "index port");
		wr(1'b1, 32'h0);
		rd(1'b1, 32'h1fff, 32'h0101, "host clear");
		eng.send(3, 1'b0, 1'b1);
		rd(1'b1, 32'h1fff, 32'h0223, "bus error");
		rd(1'b0, 32'h200, 32'h200, "send held");
		wr(1'b0, TXC | 32'h4);
		chk(38'(tx_abort_req), 38'h1, "abort request");
		repeat (8) tick();
		rd(1'b1, 32'he0, 32'h80, "aborted");
		chk(38'(tx_request), 38'h0, "abort stops");
		wr(1'b0, TXC | 32'h204);
		rd(1'b1, 32'he0, 32'h0, "set clears");
		for (int i = 0; i < 4 && tx_request === 1'b1; i++) eng.send(i, 1'b0, 1'b0);
		rd(1'b0, 32'h200, 32'h0, "send self clear");
		rd(1'b1, 32'h7, 32'h7, "drained");
		rtr_received = 1'b1;
		tick();
		rtr_received = 1'b0;
		rd(1'b0, 32'h200, 32'h200, "auto reply");
		tx_attempts_out = 1'b1;
		tick();
		tx_attempts_out = 1'b0;
		rd(1'b1, 32'h10, 32'h10, "attempts out");
		wr(1'b0, TXC | 32'h604);
		rd(1'b0, 32'h400, 32'h0, "host reset");
		// reset in mid-run
		config_mode = 1'b1;
		rst_n = 1'b0;
		tick();
		chk({36'h0, tx_request, irq_req}, 38'h0, "outputs in reset");
		rst_n = 1'b1;
		tick();
		rd(1'b0, 32'hffffffff, 32'h400, "control reset");
		rd(1'b1, 32'hffffffff, 32'h0, "status reset");
		tally_and_finish();
	end
endmodule
